// ### rtl/sswg_supervisor.v
// Register access over AHB-Lite and the placing of the registers were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "sswg_map.vh"
module sswg_supervisor (
	input wire core_clk,
	input wire rst_n,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output reg [31:0] hrdata,
	output reg hreadyout,
	output reg hresp,
	input wire supply_ok_in,
	input wire aux_monitor_a_in,
	input wire aux_monitor_b_in,
	input wire manual_reset_in,
	input wire write_protect_in,
	input wire scl_in,
	input wire sda_in,
	output reg sda_out,
	output reg sda_oe_n,
	output reg supply_reset_out,
	output reg aux_monitor_a_out,
	output reg aux_monitor_b_out,
	output reg wiper_wr_pulse,
	output reg wiper_wr_nv,
	output reg irq
);
	// Products are 32 bits wide; cut to the counter width on purpose
	localparam integer HOLD0_FULL = `SSWG_HOLD_US0 * `SSWG_CLK_MHZ;
	localparam integer HOLD1_FULL = `SSWG_HOLD_US1 * `SSWG_CLK_MHZ;
	localparam integer HOLD2_FULL = `SSWG_HOLD_US2 * `SSWG_CLK_MHZ;
	localparam integer HOLD3_FULL = `SSWG_HOLD_US3 * `SSWG_CLK_MHZ;
	localparam [`SSWG_HOLD_W-1:0] HOLD0 = HOLD0_FULL[`SSWG_HOLD_W-1:0];
	localparam [`SSWG_HOLD_W-1:0] HOLD1 = HOLD1_FULL[`SSWG_HOLD_W-1:0];
	localparam [`SSWG_HOLD_W-1:0] HOLD2 = HOLD2_FULL[`SSWG_HOLD_W-1:0];
	localparam [`SSWG_HOLD_W-1:0] HOLD3 = HOLD3_FULL[`SSWG_HOLD_W-1:0];
	localparam [1:0] ST_ASSERT = 2'h0;
	localparam [1:0] ST_HOLD = 2'h1;
	localparam [1:0] ST_RUN = 2'h2;

	// Two-stage synchronisers, one per pin; nothing reads the first stage
	// Each resets to its pin's idle level so no false edge follows reset
	wire s_supply_ok;
	wire s_aux_a;
	wire s_aux_b;
	wire s_mr;
	// Reset level zero stands for the internal pull-down
	wire s_wp;
	wire s_scl;
	wire s_sda;
	// Supply comparator
	sswg_sync2 #(.IDLE(1'b0)) u_sync_supply (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.pin_in(supply_ok_in),
		.sync_out(s_supply_ok)
	);
	// Monitor A comparator
	sswg_sync2 #(.IDLE(1'b0)) u_sync_aux_a (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.pin_in(aux_monitor_a_in),
		.sync_out(s_aux_a)
	);
	// Monitor B comparator
	sswg_sync2 #(.IDLE(1'b0)) u_sync_aux_b (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.pin_in(aux_monitor_b_in),
		.sync_out(s_aux_b)
	);
	// Manual reset, pulled down outside
	sswg_sync2 #(.IDLE(1'b0)) u_sync_mr (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.pin_in(manual_reset_in),
		.sync_out(s_mr)
	);
	// Write protect, pulled down inside
	sswg_sync2 #(.IDLE(1'b0)) u_sync_wp (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.pin_in(write_protect_in),
		.sync_out(s_wp)
	);
	// Serial clock idles high
	sswg_sync2 #(.IDLE(1'b1)) u_sync_scl (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.pin_in(scl_in),
		.sync_out(s_scl)
	);
	// Serial data idles high, input never gated
	sswg_sync2 #(.IDLE(1'b1)) u_sync_sda (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.pin_in(sda_in),
		.sync_out(s_sda)
	);

	// Bus registers
	reg [1:0] delay_sel;
	reg write_lock;
	reg write_enable_latch;
	reg [`SSWG_EV_W-1:0] irq_stat;
	reg [`SSWG_EV_W-1:0] irq_mask;
	reg [3:0] status_latch;

	// Hold time lookup from the delay select field
	reg [`SSWG_HOLD_W-1:0] hold_cycles;
	always @* begin
		case (delay_sel)
		2'h0: hold_cycles = HOLD0;
		2'h1: hold_cycles = HOLD1;
		2'h2: hold_cycles = HOLD2;
		default: hold_cycles = HOLD3;
		endcase
	end

	// Supply reset sequencer; block reset acts as power-up
	reg [1:0] state;
	reg [1:0] next_state;
	reg [`SSWG_HOLD_W-1:0] hold_cnt;
	wire rst_cause = !s_supply_ok || s_mr;
	always @* begin
		case (state)
		ST_ASSERT: next_state = rst_cause ? ST_ASSERT : ST_HOLD;
		ST_HOLD: begin
			if (rst_cause)
				next_state = ST_ASSERT;
			else if (hold_cnt >= hold_cycles - 1'b1)
				next_state = ST_RUN;
			else
				next_state = ST_HOLD;
		end
		ST_RUN: next_state = rst_cause ? ST_ASSERT : ST_RUN;
		default: next_state = ST_ASSERT;
		endcase
	end
	always @(posedge core_clk) begin
		if (!rst_n) begin
			state <= ST_ASSERT;
			hold_cnt <= {`SSWG_HOLD_W{1'b0}};
			supply_reset_out <= 1'b1;
		end else begin
			state <= next_state;
			hold_cnt <= (next_state == ST_HOLD && state == ST_HOLD) ?
				hold_cnt + 1'b1 : {`SSWG_HOLD_W{1'b0}};
			supply_reset_out <= (next_state != ST_RUN);
		end
	end

	// Monitor outputs follow the comparators directly
	always @(posedge core_clk) begin
		if (!rst_n) begin
			aux_monitor_a_out <= 1'b0;
			aux_monitor_b_out <= 1'b0;
		end else begin
			aux_monitor_a_out <= s_aux_a;
			aux_monitor_b_out <= s_aux_b;
		end
	end

	// Serial pins: clock is only watched, data only sampled
	reg scl_d;
	reg [7:0] ser_shift;
	wire scl_rise = s_scl && !scl_d;
	always @(posedge core_clk) begin
		if (!rst_n) begin
			scl_d <= 1'b1; // Idle level, no false rise
			ser_shift <= 8'h00;
			sda_out <= 1'b1;
			sda_oe_n <= 1'b1;
		end else begin
			scl_d <= s_scl;
			if (scl_rise)
				ser_shift <= {ser_shift[6:0], s_sda};
			sda_out <= 1'b1;
			sda_oe_n <= 1'b1;
		end
	end

	// AHB-Lite address phase capture
	reg dp_valid;
	reg dp_write;
	reg [7:0] dp_addr;
	always @(posedge core_clk) begin
		if (!rst_n) begin
			dp_valid <= 1'b0;
			dp_write <= 1'b0;
			dp_addr <= 8'h00;
		end else if (hready) begin
			dp_valid <= hsel && htrans[1];
			dp_write <= hwrite;
			dp_addr <= haddr[7:0];
		end
	end
	wire wr_en = dp_valid && dp_write;
	wire rd_take = hsel && htrans[1] && !hwrite && hready;

	// Wiper write request and protection check
	wire wcmd_wr = wr_en && dp_addr == `SSWG_WCMD_ADDR;
	wire wcmd_nv = hwdata[`SSWG_WCMD_NV];
	wire wr_block = !write_enable_latch ||
		(s_wp && wcmd_nv) ||
		(s_wp && write_lock);
	always @(posedge core_clk) begin
		if (!rst_n) begin
			wiper_wr_pulse <= 1'b0;
			wiper_wr_nv <= 1'b0;
		end else begin
			wiper_wr_pulse <= wcmd_wr && !wr_block;
			wiper_wr_nv <= wcmd_wr && !wr_block && wcmd_nv;
		end
	end

	// Event sources; a hardware set beats a software clear
	reg [2:0] prev_ev;
	wire [`SSWG_EV_W-1:0] ev;
	assign ev = {scl_rise, wcmd_wr && wr_block,
		s_aux_b != prev_ev[2], s_aux_a != prev_ev[1],
		s_supply_ok && !s_mr && !prev_ev[0]};

	// Previous levels for change detection
	always @(posedge core_clk) begin
		if (!rst_n)
			prev_ev <= 3'h0;
		else
			prev_ev <= {s_aux_b, s_aux_a, s_supply_ok && !s_mr};
	end

	// Status bits latch the reset output and the synchronised levels
	always @(posedge core_clk) begin
		if (!rst_n)
			status_latch <= 4'h0;
		else
			status_latch <= {s_wp, s_aux_b, s_aux_a, supply_reset_out};
	end

	// Delay select field
	always @(posedge core_clk) begin
		if (!rst_n)
			delay_sel <= `SSWG_CTRL_RESET;
		else if (wr_en && dp_addr == `SSWG_CTRL_ADDR)
			delay_sel <= hwdata[`SSWG_CTRL_SEL_HI:`SSWG_CTRL_SEL_LO];
	end

	// Write lock bit
	always @(posedge core_clk) begin
		if (!rst_n)
			write_lock <= 1'b0;
		else if (wr_en && dp_addr == `SSWG_WLOCK_ADDR)
			write_lock <= hwdata[0];
	end

	// Latch takes every wiper command's value, accepted or not
	always @(posedge core_clk) begin
		if (!rst_n)
			write_enable_latch <= 1'b0;
		else if (wcmd_wr)
			write_enable_latch <= hwdata[`SSWG_WCMD_WEL];
	end

	// Interrupt mask
	always @(posedge core_clk) begin
		if (!rst_n)
			irq_mask <= {`SSWG_EV_W{1'b0}};
		else if (wr_en && dp_addr == `SSWG_IRQ_MASK_ADDR)
			irq_mask <= hwdata[`SSWG_EV_W-1:0];
	end

	// Sticky events, write one to clear; a set in the same cycle wins
	always @(posedge core_clk) begin
		if (!rst_n)
			irq_stat <= {`SSWG_EV_W{1'b0}};
		else if (wr_en && dp_addr == `SSWG_IRQ_STAT_ADDR)
			irq_stat <= (irq_stat & ~hwdata[`SSWG_EV_W-1:0]) | ev;
		else
			irq_stat <= irq_stat | ev;
	end

	// Read data, zero-wait answer, always OKAY
	always @(posedge core_clk) begin
		if (!rst_n) begin
			hrdata <= 32'h00000000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			irq <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			irq <= |(irq_stat & irq_mask);
			if (rd_take) begin
				case (haddr[7:0])
				`SSWG_CTRL_ADDR: hrdata <= {30'h00000000, delay_sel};
				`SSWG_STAT_ADDR: hrdata <= {28'h0000000, status_latch};
				`SSWG_IRQ_STAT_ADDR: hrdata <= {27'h0000000, irq_stat};
				`SSWG_IRQ_MASK_ADDR: hrdata <= {27'h0000000, irq_mask};
				`SSWG_WLOCK_ADDR: hrdata <= {30'h00000000, write_enable_latch, write_lock};
				`SSWG_SER_ADDR: hrdata <= {24'h000000, ser_shift};
				default: hrdata <= 32'h00000000;
				endcase
			end
		end
	end
endmodule

module sswg_sync2 #(
	parameter [0:0] IDLE = 1'b0
) (
	input wire core_clk,
	input wire rst_n,
	input wire pin_in,
	output wire sync_out
);
	// First stage may go metastable; only the second one is read
	reg stage1;
	reg stage2;
	always @(posedge core_clk) begin
		if (!rst_n) begin
			stage1 <= IDLE;
			stage2 <= IDLE;
		end else begin
			stage1 <= pin_in;
			stage2 <= stage1;
		end
	end
	assign sync_out = stage2;
endmodule
`default_nettype wire

// ### rtl/sswg_map.vh
`ifndef SSWG_MAP_VH
`define SSWG_MAP_VH
// Register byte addresses
`define SSWG_CTRL_ADDR 8'h00
`define SSWG_STAT_ADDR 8'h04
`define SSWG_IRQ_STAT_ADDR 8'h08
`define SSWG_IRQ_MASK_ADDR 8'h0C
`define SSWG_WLOCK_ADDR 8'h10
`define SSWG_WCMD_ADDR 8'h14
`define SSWG_SER_ADDR 8'h18
// Control fields
`define SSWG_CTRL_SEL_LO 0
`define SSWG_CTRL_SEL_HI 1
`define SSWG_CTRL_RESET 2'h0
// Status fields
`define SSWG_STAT_RST 0
`define SSWG_STAT_AUXA 1
`define SSWG_STAT_AUXB 2
`define SSWG_STAT_WP 3
// Event bits
`define SSWG_EV_RST_RISE 0
`define SSWG_EV_AUXA_CHG 1
`define SSWG_EV_AUXB_CHG 2
`define SSWG_EV_WR_REJ 3
`define SSWG_EV_SCL_EDGE 4
`define SSWG_EV_W 5
// Write command fields
`define SSWG_WCMD_NV 0
`define SSWG_WCMD_WEL 1
// Reset hold times in microseconds per delay select code
`define SSWG_HOLD_US0 50
`define SSWG_HOLD_US1 100
`define SSWG_HOLD_US2 200
`define SSWG_HOLD_US3 400
`define SSWG_CLK_MHZ 20
`define SSWG_HOLD_W 14
`endif

// ### verification/sswg_props.sv
`timescale 1ns/10ps
`default_nettype none
module sswg_props (
	input wire core_clk,
	input wire rst_n,
	input wire hreadyout,
	input wire hresp,
	input wire supply_ok_in,
	input wire aux_monitor_a_in,
	input wire aux_monitor_b_in,
	input wire manual_reset_in,
	input wire write_protect_in,
	input wire sda_out,
	input wire sda_oe_n,
	input wire supply_reset_out,
	input wire aux_monitor_a_out,
	input wire aux_monitor_b_out,
	input wire wiper_wr_pulse,
	input wire wiper_wr_nv
);
	// Inputs settle through two flops, so outputs lag three edges
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	sequence s_wp_held; write_protect_in [*5]; endsequence
	sequence s_mr_held; manual_reset_in [*3]; endsequence
	sequence s_low_supply; !supply_ok_in [*3]; endsequence
	chk_auxb_high: assert property (aux_monitor_b_in [*3] |=> aux_monitor_b_out)
		else $error("aux b out not high");
	chk_auxb_low: assert property (!aux_monitor_b_in [*3] |=> !aux_monitor_b_out)
		else $error("aux b out not low");
	chk_auxa_follow: assert property (aux_monitor_a_in [*3] |=> aux_monitor_a_out)
		else $error("aux a out not high");
	chk_auxa_low: assert property (!aux_monitor_a_in [*3] |=> !aux_monitor_a_out)
		else $error("aux a out not low");
	chk_mr_reset: assert property (s_mr_held |=> supply_reset_out)
		else $error("manual reset ignored");
	chk_hold_min: assert property ($fell(manual_reset_in) |=> supply_reset_out [*8])
		else $error("reset hold cut short");
	chk_brown_reset: assert property (s_low_supply |=> supply_reset_out)
		else $error("low supply ignored");
	chk_nv_block: assert property (s_wp_held |=> !wiper_wr_nv)
		else $error("nv write under protect");
	chk_pulse_width: assert property (wiper_wr_pulse |=> !wiper_wr_pulse)
		else $error("wiper pulse too long");
	chk_no_drive: assert property (sda_oe_n && sda_out)
		else $error("serial line driven");
	chk_bus_okay: assert property (hreadyout && !hresp)
		else $error("bus not ready or error");
endmodule
bind sswg_supervisor sswg_props u_props (.core_clk, .rst_n, .hreadyout, .hresp,
	.supply_ok_in, .aux_monitor_a_in, .aux_monitor_b_in, .manual_reset_in,
	.write_protect_in, .sda_out, .sda_oe_n, .supply_reset_out, .aux_monitor_a_out,
	.aux_monitor_b_out, .wiper_wr_pulse, .wiper_wr_nv);
`default_nettype wire

// ### verification/sswg_host.sv
`timescale 1ns/10ps
`default_nettype none
module sswg_host (
	input wire logic go,
	input wire logic [7:0] tx,
	output var logic scl,
	output var logic sda
);
	// Both lines rest at the pull-up level between frames
	initial begin
		scl = 1'h1;
		sda = 1'h1;
	end
	// Host owns the clock: start, eight bits, stop
	always @(posedge go) begin
		#207 sda = 1'h0;
		for (int i = 7; i >= 0; i--) begin
			#100 scl = 1'h0;
			#100 sda = tx[i];
			#200 scl = 1'h1;
		end
		#200 scl = 1'h0;
		#100 sda = 1'h0;
		#100 scl = 1'h1;
		#100 sda = 1'h1;
	end
endmodule
`default_nettype wire

// ### verification/sswg_supervisor_tb.sv
`timescale 1ns/10ps
`default_nettype none
module sswg_supervisor_tb;
	logic core_clk = 1'h0, rst_n = 1'h0, hsel = 1'h0, hwrite = 1'h0, go = 1'h0, rd_ph = 1'h0;
	logic ok = 1'h1, aa = 1'h0, ab = 1'h0, mr = 1'h0, wp = 1'h0;
	logic [1:0] htrans = 2'h0;
	logic [7:0] tx = 8'h0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, exp_q[$];
	wire [31:0] hrdata;
	wire rdy, hresp, scl, sda, sdo, sdoe, ro, ao, bo, wpul, wnv, irq;
	// Open-drain wire: low if either side pulls
	wire sdw = sda & (sdoe | sdo);
	int errors = 0, check_count = 0;
	int pulses = 0, nv_pulses = 0;
	sswg_supervisor u_dut (.core_clk, .rst_n, .hsel, .haddr, .htrans, .hwrite,
		.hsize(3'h2), .hwdata, .hready(rdy), .hrdata, .hreadyout(rdy), .hresp,
		.supply_ok_in(ok), .aux_monitor_a_in(aa), .aux_monitor_b_in(ab),
		.manual_reset_in(mr), .write_protect_in(wp), .scl_in(scl), .sda_in(sdw),
		.sda_out(sdo), .sda_oe_n(sdoe), .supply_reset_out(ro), .aux_monitor_a_out(ao),
		.aux_monitor_b_out(bo), .wiper_wr_pulse(wpul), .wiper_wr_nv(wnv), .irq);
	sswg_host u_host (.go, .tx, .scl, .sda);
	initial forever #25 core_clk = ~core_clk;
	task chk(input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			errors++;
			$display("[FAIL] %0t expected %h got %h", $time, e, g);
		end
	endtask
	task test_done;
		$display("errors %0d checks %0d", errors, check_count);
		if (errors == 0 && check_count > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	task cyc(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	// One single transfer; waits are bounded
	task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		hsel <= 1'h1; htrans <= 2'h2; hwrite <= w; haddr <= {24'h0, a};
		do begin @(posedge core_clk); n++; end while (rdy !== 1'h1 && n < 20);
		if (rdy !== 1'h1) begin errors++; test_done; end
		htrans <= 2'h0; hwdata <= d;
		do begin @(posedge core_clk); n++; end while (rdy !== 1'h1 && n < 40);
		if (rdy !== 1'h1) begin errors++; test_done; end
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		ahb(1'h0, a, 32'h0);
	endtask
	// Read data is compared at the data phase edge
	always @(posedge core_clk) begin
		if (rd_ph && rdy === 1'h1) chk(exp_q.pop_front(), hrdata);
		rd_ph <= hsel && htrans[1] && !hwrite && rdy;
	end
	// Counts accepted wiper write pulses
	always @(posedge core_clk) begin
		if (wpul === 1'h1) pulses++;
		if (wnv === 1'h1) nv_pulses++;
	end
	initial begin
		cyc(60000);
		errors++;
		test_done;
	end
	initial begin
		void'($urandom(32'h4BA2));
		cyc(8); rst_n <= 1'h1;
		cyc(990); rd(8'h04, 32'h1);
		cyc(20); rd(8'h04, 32'h0);
		rd(8'h00, 32'h0); rd(8'h0C, 32'h0); rd(8'h10, 32'h0); rd(8'h1C, 32'h0);
		for (int s = 0; s < 4; s++) begin
			ahb(1'h1, 8'h00, 32'(s));
			mr <= 1'h1; cyc(5); mr <= 1'h0;
			cyc((1000 << s) - 10); rd(8'h04, 32'h1);
			cyc(20); rd(8'h04, 32'h0);
		end
		ahb(1'h1, 8'h00, 32'h0);
		ok <= 1'h0; cyc(4); rd(8'h04, 32'h1);
		chk(32'h1, {31'h0, ro});
		ok <= 1'h1; cyc(1020); rd(8'h04, 32'h0);
		repeat (6) begin
			aa <= 1'($urandom); ab <= 1'($urandom); cyc(4);
			chk({30'h0, ab, aa}, {30'h0, bo, ao});
			rd(8'h04, {29'h0, ab, aa, 1'h0});
		end
		ahb(1'h1, 8'h0C, 32'h8); ahb(1'h1, 8'h08, 32'hFF);
		ahb(1'h1, 8'h14, 32'h0); cyc(2); rd(8'h08, 32'h8);
		for (int c = 0; c < 8; c++) begin
			logic p, l, v, b;
			int p0, n0;
			{p, l, v} = c[2:0];
			b = p & (v | l);
			wp <= p; ahb(1'h1, 8'h10, 32'(l)); ahb(1'h1, 8'h14, 32'h2);
			ahb(1'h1, 8'h08, 32'hFF);
			p0 = pulses;
			n0 = nv_pulses;
			ahb(1'h1, 8'h14, {30'h0, 1'h1, v}); cyc(2);
			chk(32'(!b), pulses - p0);
			chk(32'(!b & v), nv_pulses - n0);
			rd(8'h08, 32'(b) << 3);
			chk(32'(b), 32'(irq));
		end
		wp <= 1'h0; ahb(1'h1, 8'h08, 32'hFF);
		tx <= 8'($urandom); go <= 1'h1; cyc(1); go <= 1'h0;
		cyc(100); rd(8'h08, 32'h10);
		// Stop condition's clock rise shifts one low bit in
		rd(8'h18, {24'h0, tx[6:0], 1'h0});
		test_done;
	end
endmodule
`default_nettype wire
